// *** rtl/ustx_top.sv ***
// Synchronous slave transmitter with its registers and interrupt logic.
// Assumes an external master drives the shift clock pin; software uses the
// plain register port.
//
// What this block does
// - Shift clock comes only from external pin.
// - Transmission continues while the core sleeps.
// - Clock source bit clear selects slave mode.
// - Slave transmit behaves like master transmit.
// - First word moves to shifter at once.
// - Second word waits; flag stays clear.
// - After first word, reload then set flag.
// - Enabled flag wakes chip; global enable vectors.
// - Nine-bit select shifts nine bits per word.
// - Transmit only while transmit enable set.
// - Writing holding register starts a transmission.
`default_nettype none
module ustx_top
	import ustx_pkg::*;
(
	input  wire logic       i_sys_clk,     // System clock, 100 MHz.
	input  wire logic       i_srst,        // Synchronous reset, active high.
	input  wire logic [3:0] i_addr,        // Register index.
	input  wire logic [7:0] i_wdata,       // Write data.
	input  wire logic       i_wr,          // Write strobe.
	input  wire logic       i_rd,          // Read strobe.
	output logic      [7:0] o_rdata,       // Read data, cycle after the strobe.
	input  wire logic       i_ck_pin,      // Shift clock from the external master.
	output logic            o_ck_oe,       // Clock pin drive enable, never high here.
	output logic            o_tx_data,     // Serial data pin level.
	output logic            o_tx_data_oe,  // Data pin drive enable.
	output logic            o_wake,        // Wake request to the sleeping core.
	output logic            o_vector,      // Branch-to-vector request.
	output logic            o_irq          // Event interrupt, level.
);
	import ustx_pkg::*;

	typedef struct packed {
		logic [7:0] interrupt_control;     // Interrupt control.
		logic [7:0] pie;        // Peripheral enables.
		logic [7:0] ipr;        // Peripheral priorities.
		logic [7:0] receive_status_control;      // Receive status/control.
		logic [7:0] transmit_status_control;      // Transmit status/control, stored bits.
		logic [7:0] baud;       // Divisor, unused in slave mode.
		logic [8:0] hold;       // Holding register with ninth bit.
		logic       hold_full;  // Holding register occupied.
		logic       sleep;      // Core sleep indication.
		logic [1:0] evt;        // Sticky event status.
		logic [1:0] evt_en;     // Event interrupt enables.
		logic [1:0] ck_sync;    // Two-stage pin synchroniser.
		logic       ck_prev;    // Previous synchronised clock level.
		logic [7:0] rdata;      // Read data register.
		logic       irq;        // Registered interrupt.
		logic       wake;       // Registered wake.
		logic       vector;     // Registered vector request.
		logic       dout;       // Registered data pin.
		logic       doe;        // Registered data drive enable.
	} ustx_top_t;

	ustx_top_t st_ff;          // Registered state.
	ustx_top_t nxt_st;         // Next state.
	ustx_shift_if sh ();       // Link to the shift engine.
	logic ck_fall;             // Falling edge of the synchronised shift clock.

	////////////////////////////////////////////////////////////////////////////
	// Helper functions.

	// True when the port is configured as a synchronous slave transmitter.
	function automatic logic slave_tx_on(input logic [7:0] txs, input logic [7:0] rcs);
		slave_tx_on = txs[TXS_SYNC] && !txs[TXS_CLOCK_SOURCE]
			&& rcs[RCS_PORT_ENABLE] && txs[TXS_TX_ENABLE];
	endfunction

	// Transmit flag: set when the holding register is free and transmit is on.
	function automatic logic tx_flag(input logic full, input logic on);
		tx_flag = on && !full;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Edge detection reads only the second synchroniser stage, so a
	// metastable first stage can never reach the logic. The slave never
	// drives the clock pin, so its enable stays low.
	assign ck_fall = st_ff.ck_prev && !st_ff.ck_sync[1];

	ustx_shifter u_shift (
		.i_sys_clk (i_sys_clk),
		.i_srst    (i_srst),
		.i_ck_fall (ck_fall),
		.sh        (sh)
	);

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic: register port, holding-to-shifter transfer, events.
	always_comb
	begin
		logic       on;       // Transmitter enabled.
		logic       load;     // Transfer holding into shifter this cycle.
		logic [7:0] txs_rd;   // Transmit status as read.
		logic [7:0] pir_rd;   // Flag register as read.
		logic       flag;     // Transmit flag level.
		logic [1:0] set_evt;  // Event pulses this cycle.
		on      = 1'b0;
		load    = 1'b0;
		txs_rd  = 8'h00;
		pir_rd  = 8'h00;
		flag    = 1'b0;
		set_evt = 2'b00;
		nxt_st  = st_ff;

		// Synchronise the external clock; it is a pin, so two stages.
		nxt_st.ck_sync = {st_ff.ck_sync[0], i_ck_pin};
		nxt_st.ck_prev = st_ff.ck_sync[1];

		on = slave_tx_on(st_ff.transmit_status_control, st_ff.receive_status_control);

		// The shifter takes the held word whenever it is idle and the transmitter is on; sleep has no
		// effect since the clock comes from outside.
		// The shifter's busy flag rises the cycle after a load, so the held
		// word can never be taken twice.
		load = on && st_ff.hold_full && !sh.busy;
		sh.load = load;
		sh.word = st_ff.hold;
		sh.nine = st_ff.transmit_status_control[TXS_NINE_BIT];
		if (load)
		begin
			nxt_st.hold_full = 1'b0;
			set_evt[EVT_HOLD_FREE] = 1'b1;
		end
		if (sh.done)
			set_evt[EVT_WORD_DONE] = 1'b1;

		// Read values assembled from stored bits and live status.
		txs_rd = {st_ff.transmit_status_control[7:4], 1'b0, st_ff.transmit_status_control[2],
			!sh.busy, st_ff.transmit_status_control[TXS_NINTH_DATA]};
		flag   = tx_flag(st_ff.hold_full, on);
		pir_rd = 8'h00;
		pir_rd[PIR_TX_FLAG] = flag;

		// Register writes.
		if (i_wr)
		begin
			case (i_addr)
				ADDR_INTERRUPT_CONTROL: nxt_st.interrupt_control = i_wdata;
				ADDR_IRQ_ENABLES_ONE:   nxt_st.pie    = i_wdata;
				ADDR_IRQ_PRIORITY_ONE:  nxt_st.ipr    = i_wdata;
				ADDR_RECEIVE_STATUS:    nxt_st.receive_status_control  = i_wdata;
				ADDR_TRANSMIT_STATUS:   nxt_st.transmit_status_control  = i_wdata;
				ADDR_BAUD_DIVISOR:      nxt_st.baud   = i_wdata;
				ADDR_SLEEP_CONTROL:     nxt_st.sleep  = i_wdata[0];
				ADDR_EVENT_ENABLE:      nxt_st.evt_en = i_wdata[1:0];
				ADDR_EVENT_CLEAR:       nxt_st.evt    = st_ff.evt & ~i_wdata[1:0];
				ADDR_TRANSMIT_HOLDING:
				begin
					// A write to a full holding register overwrites it; a write
					// while the shifter is loading lands after the transfer.
					nxt_st.hold      = {st_ff.transmit_status_control[TXS_NINTH_DATA], i_wdata};
					nxt_st.hold_full = 1'b1;
				end
				default:
				begin
					// Unmapped or read-only: ignored.
				end
			endcase
		end
		// Hardware set wins over a simultaneous clear.
		nxt_st.evt = nxt_st.evt | set_evt;

		// Register reads; unmapped indices return zero.
		nxt_st.rdata = 8'h00;
		if (i_rd)
		begin
			case (i_addr)
				ADDR_INTERRUPT_CONTROL: nxt_st.rdata = st_ff.interrupt_control;
				ADDR_IRQ_FLAGS_ONE:     nxt_st.rdata = pir_rd;
				ADDR_IRQ_ENABLES_ONE:   nxt_st.rdata = st_ff.pie;
				ADDR_IRQ_PRIORITY_ONE:  nxt_st.rdata = st_ff.ipr;
				ADDR_RECEIVE_STATUS:    nxt_st.rdata = st_ff.receive_status_control;
				ADDR_TRANSMIT_STATUS:   nxt_st.rdata = txs_rd;
				ADDR_BAUD_DIVISOR:      nxt_st.rdata = st_ff.baud;
				ADDR_SLEEP_CONTROL:     nxt_st.rdata = {7'h00, st_ff.sleep};
				ADDR_EVENT_STATUS:      nxt_st.rdata = {6'h00, st_ff.evt};
				ADDR_EVENT_ENABLE:      nxt_st.rdata = {6'h00, st_ff.evt_en};
				default:                nxt_st.rdata = 8'h00;
			endcase
		end

		// Wake while asleep on an enabled flag; vector needs both globals.
		nxt_st.wake   = st_ff.sleep && flag && st_ff.pie[PIR_TX_FLAG];
		nxt_st.vector = flag && st_ff.pie[PIR_TX_FLAG]
			&& st_ff.interrupt_control[ICN_GLOBAL] && st_ff.interrupt_control[ICN_PERIPHERAL];
		nxt_st.irq    = |(nxt_st.evt & st_ff.evt_en);
		nxt_st.dout   = sh.data_out;
		nxt_st.doe    = on;
	end

	////////////////////////////////////////////////////////////////////////////
	// State register; reset gives constants only.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_srst)
		begin
			st_ff           <= '0;
			st_ff.transmit_status_control     <= RST_TRANSMIT_STATUS;
			st_ff.ck_sync   <= 2'b11;
			st_ff.ck_prev   <= 1'b1;
			st_ff.dout      <= 1'b1;
		end
		else
			st_ff <= nxt_st;
	end

	assign o_rdata      = st_ff.rdata;
	assign o_ck_oe      = 1'b0;
	assign o_tx_data    = st_ff.dout;
	assign o_tx_data_oe = st_ff.doe;
	assign o_wake       = st_ff.wake;
	assign o_vector     = st_ff.vector;
	assign o_irq        = st_ff.irq;
endmodule
`default_nettype wire

// *** shared/ustx_pkg.sv ***
// Package for the synchronous slave serial transmitter.
// Assumes a single system clock domain; the shift clock arrives on a pin.
`default_nettype none
package ustx_pkg;
	// Register indices on the plain register port.
	localparam logic [3:0] ADDR_INTERRUPT_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_IRQ_FLAGS_ONE     = 4'h1;
	localparam logic [3:0] ADDR_IRQ_ENABLES_ONE   = 4'h2;
	localparam logic [3:0] ADDR_IRQ_PRIORITY_ONE  = 4'h3;
	localparam logic [3:0] ADDR_RECEIVE_STATUS    = 4'h4;
	localparam logic [3:0] ADDR_TRANSMIT_HOLDING  = 4'h5;
	localparam logic [3:0] ADDR_TRANSMIT_STATUS   = 4'h6;
	localparam logic [3:0] ADDR_BAUD_DIVISOR      = 4'h7;
	localparam logic [3:0] ADDR_SLEEP_CONTROL     = 4'h8;
	localparam logic [3:0] ADDR_EVENT_STATUS      = 4'h9;
	localparam logic [3:0] ADDR_EVENT_CLEAR       = 4'ha;
	localparam logic [3:0] ADDR_EVENT_ENABLE      = 4'hb;
	// Field positions in the transmit status/control register.
	localparam int TXS_CLOCK_SOURCE = 7;
	localparam int TXS_NINE_BIT     = 6;
	localparam int TXS_TX_ENABLE    = 5;
	localparam int TXS_SYNC         = 4;
	localparam int TXS_SHIFT_EMPTY  = 1;
	localparam int TXS_NINTH_DATA   = 0;
	// Field positions in the receive status/control register.
	localparam int RCS_PORT_ENABLE  = 7;
	localparam int RCS_SINGLE_RX    = 5;
	localparam int RCS_CONT_RX      = 4;
	// Field positions in the interrupt control and peripheral registers.
	localparam int ICN_GLOBAL       = 7;
	localparam int ICN_PERIPHERAL   = 6;
	localparam int PIR_TX_FLAG      = 4;
	// Event bits of the status, clear and enable registers.
	localparam int EVT_HOLD_FREE    = 0;
	localparam int EVT_WORD_DONE    = 1;
	// Reset values.
	localparam logic [7:0] RST_TRANSMIT_STATUS = 8'h02;
	localparam logic [7:0] RST_ZERO            = 8'h00;
endpackage
`default_nettype wire

// *** shared/ustx_shift_if.sv ***
// Interface between the register block and the shift engine.
// Assumes both ends run on the system clock.
`default_nettype none
interface ustx_shift_if;
	logic       load;      // One-cycle pulse: take a word into the shifter.
	logic [8:0] word;      // Word to shift, bit 0 first.
	logic       nine;      // High for nine-bit words.
	logic       busy;      // High while the shifter holds a word.
	logic       done;      // One-cycle pulse when the last bit has gone out.
	logic       data_out;  // Level driven on the data pin.
	modport ctrl (output load, output word, output nine, input busy, input done,
		input data_out);
	modport eng (input load, input word, input nine, output busy, output done,
		output data_out);
endinterface
`default_nettype wire

// *** rtl/ustx_shifter.sv ***
// Shift engine: moves one bit per falling edge of the external shift clock.
// Assumes the caller passes a one-cycle pulse on each falling edge of the already synchronised clock.
`default_nettype none
module ustx_shifter
	import ustx_pkg::*;
(
	input  wire logic   i_sys_clk,   // System clock.
	input  wire logic   i_srst,      // Synchronous reset, active high.
	input  wire logic   i_ck_fall,   // One-cycle pulse on a falling shift-clock edge.
	ustx_shift_if.eng   sh           // Link to the register block.
);
	import ustx_pkg::*;

	typedef struct packed {
		logic [8:0] data;   // Bits still to go, bit 0 on the pin.
		logic [3:0] left;   // Bits left including the one on the pin.
		logic       busy;   // A word is in the shifter.
		logic       done;   // Completion pulse.
		logic       dout;   // Pin level.
	} ustx_sh_t;

	ustx_sh_t st_ff;       // Registered state.
	ustx_sh_t nxt_st;      // Next state.

	////////////////////////////////////////////////////////////////////////////
	// The pin shows the current bit until the master's falling edge, then the
	// next. Keeping the data on the pin between words avoids glitches.
	always_comb
	begin
		nxt_st      = st_ff;
		nxt_st.done = 1'b0;
		if (sh.load)
		begin
			// New word: first bit goes onto the pin at once, least significant first.
			nxt_st.data = sh.word;
			nxt_st.left = sh.nine ? 4'd9 : 4'd8;
			nxt_st.busy = 1'b1;
			nxt_st.dout = sh.word[0];
		end
		else if (st_ff.busy && i_ck_fall)
		begin
			// One bit per external clock cycle.
			if (st_ff.left == 4'd1)
			begin
				nxt_st.busy = 1'b0;
				nxt_st.done = 1'b1;
			end
			else
			begin
				nxt_st.data = {1'b0, st_ff.data[8:1]};
				nxt_st.dout = st_ff.data[1];
			end
			nxt_st.left = st_ff.left - 4'd1;
		end
	end

	// State register.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_srst)
			st_ff <= '{data: 9'h000, left: 4'h0, busy: 1'b0, done: 1'b0, dout: 1'b1};
		else
			st_ff <= nxt_st;
	end

	assign sh.busy     = st_ff.busy;
	assign sh.done     = st_ff.done;
	assign sh.data_out = st_ff.dout;
endmodule
`default_nettype wire

// *** verification/ustx_master_model.sv ***
// Model of the external synchronous master that supplies the shift clock.
// Assumes the bench pulses i_go once per burst and resolves the data wire.
`default_nettype none
module ustx_master_model
(
	input  wire logic       i_go,    // Rising edge starts one burst.
	input  wire logic [3:0] i_nbits, // Clock pulses in the burst.
	input  wire logic       i_line,  // Level seen on the data wire.
	output logic            o_ck,    // Shift clock, high while idle.
	output logic      [8:0] o_got,   // Sampled bits, first bit in bit 0.
	output logic            o_busy   // High during a burst.
);
	timeunit 1ns;
	timeprecision 100ps;
	// The clock stands high between bursts so no stray edge reaches the slave.
	initial
	begin
		o_ck = 1'b1;
		o_got = 9'h000;
		o_busy = 1'b0;
	end
	// The slave shifts just after each fall, so the bit is taken as the clock
	// falls, before the slave's synchroniser lets the next bit out.
	always @(posedge i_go)
	begin
		o_busy = 1'b1;
		o_got = 9'h000;
		for (int k = 0; k < i_nbits; k++)
		begin
			#62.5 o_got[k] = i_line;
			o_ck = 1'b0;
			#62.5 o_ck = 1'b1;
		end
		#1 o_busy = 1'b0;
	end
endmodule
`default_nettype wire

// *** verification/ustx_asserts.sv ***
// Port checker for the synchronous slave transmitter.
// Assumes it is bound to ustx_top and sees only that module's ports.
`default_nettype none
module ustx_asserts
	import ustx_pkg::*;
(
	input wire logic       i_sys_clk,
	input wire logic       i_srst,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic       i_wr,
	input wire logic       i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic       i_ck_pin,
	input wire logic       o_ck_oe,
	input wire logic       o_tx_data,
	input wire logic       o_tx_data_oe,
	input wire logic       o_wake,
	input wire logic       o_vector,
	input wire logic       o_irq
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_srst);
	logic       evw;        // A write that may lower the interrupt.
	logic       ck_d;       // Pin level one cycle back.
	logic [3:0] since_fall; // Cycles since the pin fell, saturating.
	logic [3:0] since_wr;   // Cycles since a register write, saturating.
	assign evw = i_wr && (i_addr == ADDR_EVENT_CLEAR || i_addr == ADDR_EVENT_ENABLE);
	// Saturating age counters give data changes a bounded cause window.
	always_ff @(posedge i_sys_clk)
	begin
		ck_d <= i_ck_pin;
		if (i_srst)
		begin
			since_fall <= 4'hf;
			since_wr <= 4'hf;
		end
		else
		begin
			since_fall <= (ck_d && !i_ck_pin) ? 4'h0 : since_fall + {3'h0, since_fall != 4'hf};
			since_wr <= i_wr ? 4'h0 : since_wr + {3'h0, since_wr != 4'hf};
		end
	end
	////////////////////////////////////////////////////////////////////////
	clock_never_driven_a: assert property (!o_ck_oe)
		else $error("clock pin driven");
	reset_outputs_a: assert property (disable iff (1'b0) i_srst |=> !o_irq && !o_wake
		&& !o_vector && o_tx_data && !o_tx_data_oe) else $error("reset outputs wrong");
	rdata_idle_zero_a: assert property (!i_rd |=> o_rdata == RST_ZERO)
		else $error("read data without read");
	status_reset_read_a: assert property ($past(i_srst) && i_rd
		&& i_addr == ADDR_TRANSMIT_STATUS |=> o_rdata == RST_TRANSMIT_STATUS)
		else $error("status reset value wrong");
	unmapped_read_zero_a: assert property (i_rd && i_addr > ADDR_EVENT_ENABLE
		|=> o_rdata == RST_ZERO) else $error("unmapped read not zero");
	irq_sticky_a: assert property (o_irq && !evw && !$past(evw) && !$past(evw, 2)
		|=> o_irq) else $error("interrupt dropped without clear");
	oe_after_write_a: assert property ($changed(o_tx_data_oe) |-> since_wr < 4'h4)
		else $error("drive enable changed without write");
	data_change_cause_a: assert property ($changed(o_tx_data)
		|-> since_fall < 4'hc || since_wr < 4'h8) else $error("data moved without clock");
	idle_data_high_a: assert property (!o_tx_data_oe && !$past(o_tx_data_oe)
		|-> o_tx_data) else $error("idle data not high");
	cover property ($rose(o_irq));
	cover property ($rose(o_wake));
	cover property ($rose(o_vector));
endmodule
bind ustx_top ustx_asserts ustx_asserts_i (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.i_ck_pin(i_ck_pin), .o_ck_oe(o_ck_oe), .o_tx_data(o_tx_data),
	.o_tx_data_oe(o_tx_data_oe), .o_wake(o_wake), .o_vector(o_vector), .o_irq(o_irq));
`default_nettype wire

// *** verification/ustx_top_test.sv ***
// Self-checking bench for the synchronous slave transmitter.
// Assumes ustx_top, the master model and the package are compiled first.
`default_nettype none
module ustx_top_test
	import ustx_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic       i_sys_clk = 1'b0; // System clock.
	logic       i_srst = 1'b1;    // Reset, high at start.
	logic [3:0] i_addr = 4'h0;    // Register index.
	logic [7:0] i_wdata = 8'h00;  // Write data.
	logic       i_wr = 1'b0;      // Write strobe.
	logic       i_rd = 1'b0;      // Read strobe.
	logic [7:0] o_rdata;
	logic       ck, o_ck_oe, o_tx_data, o_tx_data_oe, o_wake, o_vector, o_irq;
	logic       m_go = 1'b0;      // Burst request to the master.
	logic [3:0] m_n = 4'h8;       // Burst length.
	logic [8:0] m_got;            // Bits the master collected.
	logic       m_busy;           // Master burst in progress.
	logic       tgl = 1'b0;       // Pattern seen on a released data wire.
	logic       line;             // Resolved data wire.
	logic       rd_d = 1'b0;      // Read strobe one cycle back.
	logic [7:0] v, w;             // Random payloads.
	logic [8:0] notes[$];         // Expected results, oldest first.
	int         n_fail = 0;
	int         num_checks = 0;
	int         seed = 32'h3b53_c77a;
	logic [3:0] zr[6] = '{ADDR_IRQ_FLAGS_ONE, ADDR_IRQ_ENABLES_ONE, ADDR_IRQ_PRIORITY_ONE,
		ADDR_BAUD_DIVISOR, ADDR_EVENT_STATUS, 4'hf};
	event       smp;
	// A released wire must not hold its last level, so it toggles instead.
	assign line = o_tx_data_oe ? o_tx_data : tgl;
	ustx_top ustx_top_i (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ck_pin(ck),
		.o_ck_oe(o_ck_oe), .o_tx_data(o_tx_data), .o_tx_data_oe(o_tx_data_oe),
		.o_wake(o_wake), .o_vector(o_vector), .o_irq(o_irq));
	ustx_master_model ustx_master_model_i (.i_go(m_go), .i_nbits(m_n), .i_line(line),
		.o_ck(ck), .o_got(m_got), .o_busy(m_busy));
	initial
	begin
		forever #5 i_sys_clk = ~i_sys_clk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic results();
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic check(input logic [8:0] got);
		logic [8:0] e;
		e = notes.pop_front();
		num_checks++;
		if (got !== e)
		begin
			n_fail++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
		@(posedge i_sys_clk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		notes.push_back({1'b0, e});
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		@(posedge i_sys_clk);
	endtask
	// Samples vector, wake and interrupt once the last write has landed.
	task automatic look(input logic [2:0] e);
		notes.push_back({6'h00, e});
		@(posedge i_sys_clk);
		-> smp;
		@(posedge i_sys_clk);
	endtask
	// The wait on the master is bounded so a stuck burst ends the run.
	task automatic burst(input logic [3:0] n, input logic [8:0] e);
		int k;
		notes.push_back(e);
		m_n <= n;
		m_go <= 1'b1;
		@(posedge i_sys_clk);
		m_go <= 1'b0;
		for (k = 0; k < 300 && m_busy !== 1'b0; k++)
			@(posedge i_sys_clk);
		if (k == 300)
		begin
			n_fail++;
			results();
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	// Watcher: each result that appears takes the oldest note.
	always @(posedge i_sys_clk)
	begin
		tgl <= ~tgl;
		rd_d <= i_rd;
	end
	// Read data stand only between the two edges after the strobe, so they
	// are taken at the falling edge in between, clear of the update race.
	always @(negedge i_sys_clk)
	begin
		if (rd_d)
			check({1'b0, o_rdata});
	end
	always @(negedge m_busy)
	begin
		check(m_got);
	end
	always @(smp)
	begin
		#1 check({6'h00, o_vector, o_wake, o_irq});
	end
	initial
	begin
		repeat (8) @(posedge i_sys_clk);
		i_srst <= 1'b0;
		rd(ADDR_TRANSMIT_STATUS, RST_TRANSMIT_STATUS);
		foreach (zr[j]) rd(zr[j], RST_ZERO);
		v = 8'($random(seed));
		wr(ADDR_BAUD_DIVISOR, v);
		rd(ADDR_BAUD_DIVISOR, v);
		wr(4'hf, v);
		rd(4'hf, RST_ZERO);
		wr(ADDR_RECEIVE_STATUS, 8'h80);
		wr(ADDR_IRQ_ENABLES_ONE, 8'h10);
		wr(ADDR_INTERRUPT_CONTROL, 8'hc0);
		wr(ADDR_EVENT_ENABLE, 8'h03);
		wr(ADDR_TRANSMIT_STATUS, 8'h30);
		v = 8'($random(seed));
		wr(ADDR_TRANSMIT_HOLDING, v);
		burst(4'h8, {1'b0, v});
		rd(ADDR_EVENT_STATUS, 8'h03);
		look(3'b101);
		wr(ADDR_EVENT_ENABLE, 8'h00);
		look(3'b100);
		wr(ADDR_EVENT_CLEAR, 8'h03);
		wr(ADDR_EVENT_ENABLE, 8'h03);
		look(3'b100);
		// Two words queued while asleep: one shifts, one waits.
		wr(ADDR_SLEEP_CONTROL, 8'h01);
		v = 8'($random(seed));
		w = 8'($random(seed));
		wr(ADDR_TRANSMIT_HOLDING, v);
		repeat (3) @(posedge i_sys_clk);
		wr(ADDR_TRANSMIT_HOLDING, w);
		rd(ADDR_IRQ_FLAGS_ONE, 8'h00);
		burst(4'h8, {1'b0, v});
		repeat (4) @(posedge i_sys_clk);
		rd(ADDR_IRQ_FLAGS_ONE, 8'h10);
		look(3'b111);
		burst(4'h8, {1'b0, w});
		wr(ADDR_SLEEP_CONTROL, 8'h00);
		wr(ADDR_TRANSMIT_STATUS, 8'h71);
		v = 8'($random(seed));
		wr(ADDR_TRANSMIT_HOLDING, v);
		rd(ADDR_TRANSMIT_STATUS, 8'h71);
		burst(4'h9, {1'b1, v});
		rd(ADDR_TRANSMIT_STATUS, 8'h73);
		wr(ADDR_TRANSMIT_STATUS, 8'h10);
		wr(ADDR_TRANSMIT_HOLDING, 8'($random(seed)));
		repeat (4) @(posedge i_sys_clk);
		rd(ADDR_TRANSMIT_STATUS, 8'h12);
		i_srst <= 1'b1;
		repeat (2) @(posedge i_sys_clk);
		i_srst <= 1'b0;
		rd(ADDR_TRANSMIT_STATUS, RST_TRANSMIT_STATUS);
		results();
	end
endmodule
`default_nettype wire
